// ==== rtl/ep_ctl_pkg.sv ====
// package: register map, field positions, reset values, handshake codes
//------------------------------------------------------------
// Behaviour
// - ep0 receive stall set: every OUT to endpoint 0 gets STALL.
// - SETUP to endpoint 0 is always ACKed, even when stalled.
// - SETUP or bus reset clears both endpoint 0 stall bits.
// - stall bit set by engine or by firmware writing 1.
// - firmware writing 0 to a stall bit leaves it unchanged.
// - receive bit 3 shows toggle of last received data packet.
// - ep0 receive bit 0 reads 1 when engine enabled reception.
// - firmware writes 1 to transmit bit 4 to arm ep0 transmission.
// - while ep0 transmission armed and ep0 receive stall clear, OUT to endpoint 0 gets NAK.
// - engine clears ep0 transmit bit once the packet is sent.
// - ep0 transmit stall set: IN to endpoint 0 gets STALL.
// - ep0 transmit bit 0 reads 1 when engine enabled transmission.
// - ep1 receive stall set: OUT to endpoint 1 gets STALL.
// - ep1 stall clears on clear-feature halt for ep1 or bus reset.
// - ep1 receive bit 0 is read-write; 1 enables ep1 reception.
// - reserved bits read 0 and ignore writes.
// - set-feature halt sets that endpoint's stall and flags status.
//------------------------------------------------------------
package ep_ctl_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0]  EP0_RX_IDX    = 8'hAF;
  localparam logic [7:0]  EP0_TX_IDX    = 8'hB1;
  localparam logic [7:0]  EP1_RX_IDX    = 8'hB2;
  localparam logic [7:0]  HALT_STAT_IDX = 8'hB0;
  // field positions
  localparam int          ENABLE_BIT    = 0;
  localparam int          STALL_BIT     = 2;
  localparam int          TOGGLE_BIT    = 3;
  localparam int          ARM_BIT       = 4;
  localparam int          SET_HALT_BIT  = 7;
  localparam int          CLR_HALT_BIT  = 6;
  localparam logic [7:0]  CTL_RESET     = 8'h00;
  // handshake answer codes
  typedef enum logic [1:0] {
    HS_NONE  = 2'h0,
    HS_ACK   = 2'h1,
    HS_NAK   = 2'h2,
    HS_STALL = 2'h3
  } handshake_t;
  // token kinds from the engine
  typedef enum logic [1:0] {
    TOK_OUT   = 2'h0,
    TOK_IN    = 2'h1,
    TOK_SETUP = 2'h2
  } token_t;
endpackage : ep_ctl_pkg

// ==== rtl/sticky_bit.sv ====
// sticky set/clear bit where hardware set wins over clear
module sticky_bit (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      q_o
);
  logic q_d;

  // set wins over clear
  always_comb begin
    q_d = q_o;
    if (clr_i) begin
      q_d = 1'b0;
    end
    if (set_i) begin
      q_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_o <= 1'b0;
    end else begin
      q_o <= q_d;
    end
  end
endmodule : sticky_bit

// ==== rtl/usb_endpoint_control_regs.sv ====
// endpoint 0/1 control registers with axi4-lite slave and handshake logic
module usb_endpoint_control_regs
  import ep_ctl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  // axi4-lite slave
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // serial interface engine side
  input  wire logic        bus_reset,
  input  wire logic        tok_valid,
  input  wire logic [1:0]  tok_kind,
  input  wire logic        tok_ep1,
  input  wire logic        data_rx_valid,
  input  wire logic        data_rx_ep1,
  input  wire logic        data_rx_toggle,
  input  wire logic        ep0_rx_en,
  input  wire logic        ep0_tx_en,
  input  wire logic        ep0_tx_done,
  input  wire logic        set_halt,
  input  wire logic [1:0]  set_halt_sel,
  input  wire logic        clr_halt_ep1,
  output logic             ep0_rx_stall,
  output logic             ep0_tx_stall,
  output logic             ep0_tx_armed,
  output logic             ep1_rx_stall,
  output logic             ep1_rx_enable,
  output logic [1:0]       handshake,
  output logic             handshake_valid
);
  //------------------------------------------------------------
  // register state
  //------------------------------------------------------------
  logic       t0_q, t0_d, t1_q, t1_d, en1_q, en1_d, arm_q, arm_d;
  logic       ren0_q, ren0_d, ten0_q, ten0_d;
  logic       fw_wr, setup_in;
  logic [7:0] widx;
  logic [7:0] wbyte;
  logic       s0r, s0t, s1r, sh_q, ch_q;
  logic [1:0] hs_q, hs_d;
  logic       hsv_q, hsv_d;

  //------------------------------------------------------------
  // axi write channel
  //------------------------------------------------------------
  logic       aw_q, aw_d, w_q, w_d, bv_q, bv_d;
  logic [9:0] awa_q, awa_d;
  logic [7:0] wd_q, wd_d;
  logic       wen_q, wen_d;

  // latch address and data in either order, answer once both held
  always_comb begin
    aw_d  = aw_q;
    w_d   = w_q;
    bv_d  = bv_q;
    awa_d = awa_q;
    wd_d  = wd_q;
    wen_d = wen_q;
    if (s_axi_awvalid && !aw_q && !bv_q) begin
      aw_d  = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q && !bv_q) begin
      w_d   = 1'b1;
      wd_d  = s_axi_wdata[7:0];
      wen_d = s_axi_wstrb[0];
    end
    if (aw_q && w_q) begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      bv_d = 1'b1;
    end
    if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_q  <= 1'b0;
      w_q   <= 1'b0;
      bv_q  <= 1'b0;
      awa_q <= 10'h000;
      wd_q  <= 8'h00;
      wen_q <= 1'b0;
    end else begin
      aw_q  <= aw_d;
      w_q   <= w_d;
      bv_q  <= bv_d;
      awa_q <= awa_d;
      wd_q  <= wd_d;
      wen_q <= wen_d;
    end
  end

  assign fw_wr         = aw_q && w_q && wen_q;
  assign widx          = awa_q[9:2];
  assign wbyte         = wd_q;
  assign s_axi_awready = !aw_q && !bv_q;
  assign s_axi_wready  = !w_q && !bv_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = 2'h0;

  //------------------------------------------------------------
  // axi read channel
  //------------------------------------------------------------
  logic        rv_q, rv_d;
  logic [31:0] rd_q, rd_d;
  logic [7:0]  ridx, rbyte;

  assign ridx = s_axi_araddr[9:2];

  // read mux; reserved bits and unmapped words read zero
  always_comb begin
    rbyte = 8'h00;
    unique case (ridx)
      EP0_RX_IDX: begin
        rbyte[TOGGLE_BIT] = t0_q;
        rbyte[STALL_BIT]  = s0r;
        rbyte[ENABLE_BIT] = ren0_q;
      end
      EP0_TX_IDX: begin
        rbyte[ARM_BIT]    = arm_q;
        rbyte[STALL_BIT]  = s0t;
        rbyte[ENABLE_BIT] = ten0_q;
      end
      EP1_RX_IDX: begin
        rbyte[TOGGLE_BIT] = t1_q;
        rbyte[STALL_BIT]  = s1r;
        rbyte[ENABLE_BIT] = en1_q;
      end
      HALT_STAT_IDX: begin
        rbyte[SET_HALT_BIT] = sh_q;
        rbyte[CLR_HALT_BIT] = ch_q;
      end
      default: rbyte = 8'h00;
    endcase
    rv_d = rv_q;
    rd_d = rd_q;
    if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end
    if (s_axi_arvalid && !rv_q) begin
      rv_d = 1'b1;
      rd_d = {24'h000000, rbyte};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rv_q <= 1'b0;
      rd_q <= 32'h00000000;
    end else begin
      rv_q <= rv_d;
      rd_q <= rd_d;
    end
  end

  assign s_axi_arready = !rv_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = 2'h0;

  //------------------------------------------------------------
  // stall bits
  //------------------------------------------------------------
  logic fw_s0r, fw_s0t, fw_s1r, hw_s0r, hw_s0t, hw_s1r;

  assign setup_in = tok_valid && (tok_kind == TOK_SETUP) && !tok_ep1;
  // only a written 1 sets; a written 0 is ignored
  assign fw_s0r = fw_wr && (widx == EP0_RX_IDX) && wbyte[STALL_BIT];
  assign fw_s0t = fw_wr && (widx == EP0_TX_IDX) && wbyte[STALL_BIT];
  assign fw_s1r = fw_wr && (widx == EP1_RX_IDX) && wbyte[STALL_BIT];
  assign hw_s0r = set_halt && (set_halt_sel == 2'h0);
  assign hw_s0t = set_halt && (set_halt_sel == 2'h1);
  assign hw_s1r = set_halt && (set_halt_sel == 2'h2);

  sticky_bit u_s0r (
    .clk   (clk),
    .rst_n (rst_n),
    .set_i (fw_s0r || hw_s0r),
    .clr_i (setup_in || bus_reset),
    .q_o   (s0r)
  );
  sticky_bit u_s0t (
    .clk   (clk),
    .rst_n (rst_n),
    .set_i (fw_s0t || hw_s0t),
    .clr_i (setup_in || bus_reset),
    .q_o   (s0t)
  );
  sticky_bit u_s1r (
    .clk   (clk),
    .rst_n (rst_n),
    .set_i (fw_s1r || hw_s1r),
    .clr_i (clr_halt_ep1 || bus_reset),
    .q_o   (s1r)
  );
  // halt event flags, cleared by writing 1
  sticky_bit u_sh (
    .clk   (clk),
    .rst_n (rst_n),
    .set_i (set_halt),
    .clr_i (fw_wr && (widx == HALT_STAT_IDX) && wbyte[SET_HALT_BIT]),
    .q_o   (sh_q)
  );
  sticky_bit u_ch (
    .clk   (clk),
    .rst_n (rst_n),
    .set_i (clr_halt_ep1),
    .clr_i (fw_wr && (widx == HALT_STAT_IDX) && wbyte[CLR_HALT_BIT]),
    .q_o   (ch_q)
  );

  //------------------------------------------------------------
  // toggle, enables, arm, handshake answer
  //------------------------------------------------------------
  always_comb begin
    t0_d   = t0_q;
    t1_d   = t1_q;
    en1_d  = en1_q;
    arm_d  = arm_q;
    ren0_d = ep0_rx_en;
    ten0_d = ep0_tx_en;
    if (data_rx_valid && !data_rx_ep1) begin
      t0_d = data_rx_toggle;
    end
    if (data_rx_valid && data_rx_ep1) begin
      t1_d = data_rx_toggle;
    end
    if (fw_wr && (widx == EP1_RX_IDX)) begin
      en1_d = wbyte[ENABLE_BIT];
    end
    if (ep0_tx_done || bus_reset) begin
      arm_d = 1'b0;
    end
    if (fw_wr && (widx == EP0_TX_IDX) && wbyte[ARM_BIT]) begin
      arm_d = 1'b1;
    end
    hsv_d = tok_valid;
    hs_d  = HS_NONE;
    if (tok_valid) begin
      hs_d = HS_ACK;
      unique case (tok_kind)
        TOK_SETUP: hs_d = HS_ACK;
        TOK_OUT: begin
          if (tok_ep1) begin
            if (s1r) hs_d = HS_STALL;
          end else if (s0r) begin
            hs_d = HS_STALL;
          end else if (arm_q) begin
            hs_d = HS_NAK;
          end
        end
        TOK_IN: begin
          if (!tok_ep1 && s0t) hs_d = HS_STALL;
        end
        default: hs_d = HS_NONE;
      endcase
    end
  end

  // all control state zero after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t0_q   <= CTL_RESET[TOGGLE_BIT];
      t1_q   <= CTL_RESET[TOGGLE_BIT];
      en1_q  <= CTL_RESET[ENABLE_BIT];
      arm_q  <= CTL_RESET[ARM_BIT];
      ren0_q <= 1'b0;
      ten0_q <= 1'b0;
      hs_q   <= HS_NONE;
      hsv_q  <= 1'b0;
    end else begin
      t0_q   <= t0_d;
      t1_q   <= t1_d;
      en1_q  <= en1_d;
      arm_q  <= arm_d;
      ren0_q <= ren0_d;
      ten0_q <= ten0_d;
      hs_q   <= hs_d;
      hsv_q  <= hsv_d;
    end
  end

  assign ep0_rx_stall    = s0r;
  assign ep0_tx_stall    = s0t;
  assign ep0_tx_armed    = arm_q;
  assign ep1_rx_stall    = s1r;
  assign ep1_rx_enable   = en1_q;
  assign handshake       = hs_q;
  assign handshake_valid = hsv_q;

  //------------------------------------------------------------
  // assertions
  //------------------------------------------------------------
  sequence out_ep0_s;
    tok_valid && tok_kind == TOK_OUT && !tok_ep1;
  endsequence

  ep0_out_stall_a: assert property (@(posedge clk) disable iff (!rst_n)
    out_ep0_s and s0r |=> handshake == HS_STALL) else $error("ep0 out not stalled");
  setup_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
    setup_in |=> handshake == HS_ACK && handshake_valid) else $error("setup not acked");
  setup_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (setup_in || bus_reset) && !set_halt && !fw_wr |=> !s0r && !s0t) else $error("ep0 stall not cleared");
  zero_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    s1r && !clr_halt_ep1 && !bus_reset |=> s1r) else $error("stall lost by write");
  toggle_track_a: assert property (@(posedge clk) disable iff (!rst_n)
    data_rx_valid && !data_rx_ep1 |=> t0_q == $past(data_rx_toggle)) else $error("toggle not tracked");
  armed_nak_a: assert property (@(posedge clk) disable iff (!rst_n)
    out_ep0_s and (arm_q && !s0r) |=> handshake == HS_NAK) else $error("armed out not naked");
  done_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    ep0_tx_done && !fw_wr |=> !ep0_tx_armed) else $error("arm not cleared");
  ep0_in_stall_a: assert property (@(posedge clk) disable iff (!rst_n)
    tok_valid && tok_kind == TOK_IN && !tok_ep1 && s0t |=> handshake == HS_STALL) else $error("in not stalled");
  ep1_out_stall_a: assert property (@(posedge clk) disable iff (!rst_n)
    tok_valid && tok_kind == TOK_OUT && tok_ep1 && s1r |=> handshake == HS_STALL) else $error("ep1 not stalled");
  ep1_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    clr_halt_ep1 && !set_halt && !fw_wr |=> !s1r) else $error("ep1 stall not cleared");
endmodule : usb_endpoint_control_regs

// ==== bench/sie_model.sv ====
// engine-side model: tokens, data packets, halt requests, bus reset
module sie_model
  import ep_ctl_pkg::*;
(
  input  wire logic       clk,
  output logic            bus_reset,
  output logic            tok_valid,
  output logic [1:0]      tok_kind,
  output logic            tok_ep1,
  output logic            data_rx_valid,
  output logic            data_rx_ep1,
  output logic            data_rx_toggle,
  output logic            ep0_rx_en,
  output logic            ep0_tx_en,
  output logic            ep0_tx_done,
  output logic            set_halt,
  output logic [1:0]      set_halt_sel,
  output logic            clr_halt_ep1,
  input  wire logic [1:0] handshake,
  input  wire logic       handshake_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {bus_reset, tok_valid, tok_ep1, data_rx_valid, data_rx_ep1, data_rx_toggle} = '0;
    {ep0_rx_en, ep0_tx_en, ep0_tx_done, set_halt, clr_halt_ep1, tok_kind, set_halt_sel} = '1;
    {ep0_rx_en, ep0_tx_en, ep0_tx_done, set_halt, clr_halt_ep1} = '0;
  end
  // one token held for one cycle; answer taken 1 ns after the edge that ends it
  task automatic token(input token_t kind, input logic ep1, output logic [2:0] hs);
    @(posedge clk);
    tok_valid <= 1'b1;
    tok_kind  <= kind;
    tok_ep1   <= ep1;
    @(posedge clk);
    tok_valid <= 1'b0;
    tok_kind  <= ~2'(kind); // idle qualifiers do not keep last value
    tok_ep1   <= ~ep1;
    #1;
    hs = {handshake_valid, handshake};
  endtask : token
  // one-cycle engine event: 0 bus reset, 1 data packet, 2 set halt, 3 clear halt, 4 packet sent
  task automatic pulse(input int kind, input logic [1:0] arg);
    @(posedge clk);
    case (kind)
      0: bus_reset <= 1'b1;
      1: begin
        data_rx_valid  <= 1'b1;
        data_rx_ep1    <= arg[0];
        data_rx_toggle <= arg[1];
      end
      2: begin
        set_halt     <= 1'b1;
        set_halt_sel <= arg;
      end
      3: clr_halt_ep1 <= 1'b1;
      default: ep0_tx_done <= 1'b1;
    endcase
    @(posedge clk);
    {bus_reset, data_rx_valid, set_halt, clr_halt_ep1, ep0_tx_done} <= '0;
    data_rx_ep1    <= ~arg[0];
    data_rx_toggle <= ~arg[1];
    set_halt_sel   <= ~arg;
  endtask : pulse
  // engine enable levels, changed just after an edge
  task automatic enables(input logic rx, input logic tx);
    @(posedge clk);
    ep0_rx_en <= rx;
    ep0_tx_en <= tx;
  endtask : enables
endmodule : sie_model

// ==== bench/usb_endpoint_control_regs_bench.sv ====
// self-checking bench for the endpoint control registers
module usb_endpoint_control_regs_bench;
  import ep_ctl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, bus_reset, tok_valid, tok_ep1;
  logic data_rx_valid, data_rx_ep1, data_rx_toggle, ep0_rx_en, ep0_tx_en, ep0_tx_done;
  logic set_halt, clr_halt_ep1, hv, s0, s1, s2, s3, en1;
  logic [1:0] bresp, rresp, tok_kind, set_halt_sel, hsk;
  logic [9:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [2:0] hs;
  int err_total, n_tests;
  usb_endpoint_control_regs usb_endpoint_control_regs_i (.clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .bus_reset(bus_reset), .tok_valid(tok_valid), .tok_kind(tok_kind),
    .tok_ep1(tok_ep1), .data_rx_valid(data_rx_valid), .data_rx_ep1(data_rx_ep1),
    .data_rx_toggle(data_rx_toggle), .ep0_rx_en(ep0_rx_en), .ep0_tx_en(ep0_tx_en),
    .ep0_tx_done(ep0_tx_done), .set_halt(set_halt), .set_halt_sel(set_halt_sel),
    .clr_halt_ep1(clr_halt_ep1), .ep0_rx_stall(s0), .ep0_tx_stall(s1), .ep0_tx_armed(s2),
    .ep1_rx_stall(s3), .ep1_rx_enable(en1), .handshake(hsk), .handshake_valid(hv));
  sie_model sie_model_i (.clk(clk), .bus_reset(bus_reset), .tok_valid(tok_valid), .tok_kind(tok_kind),
    .tok_ep1(tok_ep1), .data_rx_valid(data_rx_valid), .data_rx_ep1(data_rx_ep1),
    .data_rx_toggle(data_rx_toggle), .ep0_rx_en(ep0_rx_en), .ep0_tx_en(ep0_tx_en),
    .ep0_tx_done(ep0_tx_done), .set_halt(set_halt), .set_halt_sel(set_halt_sel),
    .clr_halt_ep1(clr_halt_ep1), .handshake(hsk), .handshake_valid(hv));
  //----------------------------------------
  // checking and closing
  //----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic hang();
    err_total++;
    summarize();
  endtask : hang
  //----------------------------------------
  // axi4-lite master: index to byte address is times four
  //----------------------------------------
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    int n;
    logic a, w, ra, rw;
    a = 1'b1;
    w = 1'b1;
    @(posedge clk);
    {awvalid, wvalid, bready} <= 3'h7;
    awaddr <= {idx, 2'h0};
    wdata  <= {24'h0, d};
    // each channel held until the edge at which its ready is high
    for (n = 0; n < 20 && (a || w); n++) begin
      @(negedge clk);
      ra = awready;
      rw = wready;
      @(posedge clk);
      if (a && ra === 1'b1) begin
        awvalid <= 1'b0;
        a = 1'b0;
      end
      if (w && rw === 1'b1) begin
        wvalid <= 1'b0;
        w = 1'b0;
      end
    end
    if (a || w) hang();
    for (n = 0; n < 20; n++) begin
      @(negedge clk);
      if (bvalid === 1'b1) break;
    end
    if (n == 20) hang();
    @(posedge clk);
    chk(bresp, 2'h0);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    int n;
    @(posedge clk);
    {arvalid, rready} <= 2'h3;
    araddr <= {idx, 2'h0};
    for (n = 0; n < 20; n++) begin
      @(negedge clk);
      if (arready === 1'b1) break;
    end
    if (n == 20) hang();
    @(posedge clk);
    arvalid <= 1'b0;
    for (n = 0; n < 20; n++) begin
      @(negedge clk);
      if (rvalid === 1'b1) break;
    end
    if (n == 20) hang();
    // data taken at the edge that sees rvalid with rready
    @(posedge clk);
    chk(rdata, {24'h0, exp});
    rready <= 1'b0;
  endtask : rd
  task automatic tok(input token_t k, input logic ep1, input handshake_t exp);
    sie_model_i.token(k, ep1, hs);
    chk(hs, {1'b1, exp});
  endtask : tok
  //----------------------------------------
  // scenarios
  //----------------------------------------
  task automatic t_reset();
    chk({s0, s1, s2, s3, en1, hv}, 6'h00);
    rd(EP0_RX_IDX, 8'h00);
    rd(EP0_TX_IDX, 8'h00);
    rd(EP1_RX_IDX, 8'h00);
    rd(8'h10, 8'h00);
  endtask : t_reset
  task automatic t_ep0_stall();
    wr(EP0_RX_IDX, 8'hFF);
    rd(EP0_RX_IDX, 8'h04);
    chk(s0, 1'b1);
    wr(EP0_RX_IDX, 8'h00);
    rd(EP0_RX_IDX, 8'h04);
    wr(EP0_TX_IDX, 8'hEF);
    rd(EP0_TX_IDX, 8'h04);
    chk(s1, 1'b1);
    tok(TOK_OUT, 1'b0, HS_STALL);
    tok(TOK_IN, 1'b0, HS_STALL);
    tok(TOK_SETUP, 1'b0, HS_ACK);
    rd(EP0_RX_IDX, 8'h00);
    rd(EP0_TX_IDX, 8'h00);
    chk({s0, s1}, 2'h0);
  endtask : t_ep0_stall
  task automatic t_arm();
    wr(EP0_TX_IDX, 8'h10);
    rd(EP0_TX_IDX, 8'h10);
    chk(s2, 1'b1);
    tok(TOK_OUT, 1'b0, HS_NAK);
    sie_model_i.pulse(4, 2'h0);
    rd(EP0_TX_IDX, 8'h00);
    chk(s2, 1'b0);
    tok(TOK_OUT, 1'b0, HS_ACK);
  endtask : t_arm
  task automatic t_status_bits();
    sie_model_i.enables(1'b1, 1'b1);
    sie_model_i.pulse(1, 2'h2);
    sie_model_i.pulse(1, 2'h3);
    rd(EP0_RX_IDX, 8'h09);
    rd(EP0_TX_IDX, 8'h01);
    rd(EP1_RX_IDX, 8'h08);
  endtask : t_status_bits
  task automatic t_ep1();
    wr(EP1_RX_IDX, 8'hFF);
    rd(EP1_RX_IDX, 8'h0D);
    chk(en1, 1'b1);
    chk(s3, 1'b1);
    tok(TOK_OUT, 1'b1, HS_STALL);
    sie_model_i.pulse(3, 2'h0);
    rd(EP1_RX_IDX, 8'h09);
    chk(s3, 1'b0);
    sie_model_i.pulse(2, 2'h2);
    rd(EP1_RX_IDX, 8'h0D);
    rd(HALT_STAT_IDX, 8'hC0);
    wr(HALT_STAT_IDX, 8'h80);
    rd(HALT_STAT_IDX, 8'h40);
    sie_model_i.pulse(2, 2'h1);
    rd(EP0_TX_IDX, 8'h05);
    sie_model_i.pulse(0, 2'h0);
    rd(EP1_RX_IDX, 8'h09);
    rd(EP0_TX_IDX, 8'h01);
    wr(EP1_RX_IDX, 8'h00);
    rd(EP1_RX_IDX, 8'h08);
  endtask : t_ep1
  // reset in mid-run with stall, enable and status set
  task automatic t_mid_reset();
    wr(EP1_RX_IDX, 8'h05);
    sie_model_i.pulse(2, 2'h0);
    @(negedge clk);
    chk({s0, s3, en1}, 3'h7);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({s0, s1, s2, s3, en1, hv}, 6'h00);
    rst_n <= 1'b1;
    rd(EP1_RX_IDX, 8'h00);
    rd(HALT_STAT_IDX, 8'h00);
  endtask : t_mid_reset
  //----------------------------------------
  // clock, reset, main sequence, hang guard
  //----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    err_total = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_ep0_stall();
    t_arm();
    t_status_bits();
    t_ep1();
    t_mid_reset();
    summarize();
  end
  initial begin
    #2000000;
    hang();
  end
endmodule : usb_endpoint_control_regs_bench
